// file: rtl/ams_pkg.sv
// package for the converter input-selection block: register map, field layout,
// reset values and the multiplexer select bundle.
// assumes a 16-bit register port with word indices and a single core clock.
package ams_pkg;

    // register port shape
    localparam int unsigned AMS_ADDR_W = 3;
    localparam int unsigned AMS_DATA_W = 16;

    // register indices
    localparam logic [2:0] AMS_ADDR_CH123  = 3'h0;
    localparam logic [2:0] AMS_ADDR_CH0    = 3'h1;
    localparam logic [2:0] AMS_ADDR_SCAN   = 3'h2;
    localparam logic [2:0] AMS_ADDR_PIN_DIGITAL_MODE_BITS   = 3'h3;
    localparam logic [2:0] AMS_ADDR_CTRL   = 3'h4;
    localparam logic [2:0] AMS_ADDR_STATUS = 3'h5;

    // implemented-bit masks: everything else ignores writes and reads zero
    localparam logic [15:0] AMS_CH123_MASK = 16'h0707;
    localparam logic [15:0] AMS_CH0_MASK   = 16'h9f9f;
    localparam logic [15:0] AMS_SCAN_MASK  = 16'h01ff;
    localparam logic [15:0] AMS_PIN_DIGITAL_MODE_BITS_MASK  = 16'h01ff;
    localparam logic [15:0] AMS_CTRL_MASK  = 16'h000f;

    // values after reset
    localparam logic [15:0] AMS_REG_RESET  = 16'h0000;

    // field positions in the group select register
    localparam int unsigned AMS_GRP_NEG_B_LSB = 9;
    localparam int unsigned AMS_GRP_POS_B     = 8;
    localparam int unsigned AMS_GRP_NEG_A_LSB = 1;
    localparam int unsigned AMS_GRP_POS_A     = 0;

    // field positions in the channel 0 select register
    localparam int unsigned AMS_FIRST_NEG_B     = 15;
    localparam int unsigned AMS_FIRST_POS_B_LSB = 8;
    localparam int unsigned AMS_FIRST_NEG_A     = 7;
    localparam int unsigned AMS_FIRST_POS_A_LSB = 0;

    // field positions in the control register
    localparam int unsigned AMS_CTRL_RES_MODE = 0;
    localparam int unsigned AMS_CTRL_SCAN_EN  = 1;
    localparam int unsigned AMS_CTRL_ALT      = 2;
    localparam int unsigned AMS_CTRL_DISABLE  = 3;

    // field position in the status register
    localparam int unsigned AMS_STAT_SET_B = 4;

    // analog input count on the larger and the smaller variant
    localparam int unsigned AMS_NUM_AN   = 9;
    localparam int unsigned AMS_SMALL_AN = 6;

    // group negative-select codes
    localparam logic [1:0] AMS_NEG_VREF_0 = 2'h0;
    localparam logic [1:0] AMS_NEG_VREF_1 = 2'h1;
    localparam logic [1:0] AMS_NEG_AN678  = 2'h2;
    localparam logic [1:0] AMS_NEG_RSVD   = 2'h3;

    // which sample set drives the multiplexer
    typedef enum logic
    {
        AMS_SET_A = 1'b0,
        AMS_SET_B = 1'b1
    } ams_set_t;

    // select bundle handed to the analog multiplexer
    typedef struct packed
    {
        logic       set_b;          // set B selects are in force
        logic [3:0] ch0_pos;        // analog input index for channel 0 positive
        logic       ch0_low_ref;    // channel 0 positive takes the low reference
        logic       ch0_neg_an1;    // channel 0 negative is input 1, else negative reference
        logic       grp_pos_upper;  // channels 1..3 positive take inputs 3..5, else 0..2
        logic       grp_neg_an678;  // channels 1..3 negative take inputs 6..8
        logic       ch0_reserved;   // channel 0 positive code has no input
        logic       grp_reserved;   // channels 1..3 code is reserved in this mode
    } ams_mux_sel_t;

endpackage

// file: rtl/ams_scan_next.sv
// next scan position finder for the channel 0 scan sequence.
// assumes a nine-bit include mask and a current index in range 0..8.
`timescale 1ns/1ps

module ams_scan_next
    import ams_pkg::*;
(
    // scan state
    input  wire logic [8:0] mask_i,
    input  wire logic [3:0] cur_i,
    // answer
    output logic      [3:0] next_o
);

    logic [8:0] above;

    // per input: enabled and strictly above the current position
    genvar gi;
    generate
        for (gi = 0; gi < AMS_NUM_AN; gi = gi + 1)
        begin : g_above
            assign above[gi] = mask_i[gi] && (4'(gi) > cur_i);
        end
    endgenerate

    // lowest enabled above the current one, else wrap to lowest enabled
    always_comb
    begin
        next_o = cur_i;
        for (int i = AMS_NUM_AN - 1; i >= 0; i--)
        begin
            if (mask_i[i])
                next_o = 4'(i);
        end
        for (int i = AMS_NUM_AN - 1; i >= 0; i--)
        begin
            if (above[i])
                next_o = 4'(i);
        end
    end

endmodule // ams_scan_next

// file: rtl/ams_input_select.sv
// input-selection control of a multi-channel sample-and-hold converter:
// channel select, scan mask and pin mode registers plus the live mux selects.
// assumes the converter core pulses sample_done_i once per finished sample,
// synchronous to core_clk_i, and a master that never overlaps strobes.
//
// Overview of operation
// R1: resolution mode bit set means 12-bit one channel, clear 10-bit four channels
// R2: group negative select B: 00/01 reference, 10 inputs 6-8 large only, else reserved
// R3: group positive select B: one gives inputs 3-5, zero 0-2, reserved in 12-bit
// R4: group negative select A uses the same coding as set B
// R5: group positive select A: one gives inputs 3-5, zero 0-2, reserved in 12-bit
// R6: channel 0 negative select B: one gives input 1, zero negative reference
// R7: channel 0 positive select B code N routes input N, up to 8 or 5
// R8: channel 0 negative select A: one gives input 1, zero negative reference
// R9: channel 0 positive select A code N routes input N, same range
// R10: unimplemented register bits ignore writes and read zero
// R11: each scan mask bit includes its input in the channel 0 scan
// R12: all mask bits writable; absent scanned input converts the low reference
// R13: pin config bit set makes pin digital, clear keeps it analog
// R14: config bits of absent pins stay read-write but drive nothing
// R15: module disable overrides config bits, all shared pins become digital
// R16: implemented register bits clear to zero at reset
// R17: scan enable makes channel 0 positive in set A follow the scan
// R18: alternate bit set swaps A and B each sample, clear always A
// R19: scan steps to next enabled input upward after each sample, wrapping; code steps only after set A samples
`timescale 1ns/1ps

module ams_input_select
    import ams_pkg::*;
#(
    parameter int unsigned AN_COUNT = AMS_NUM_AN  // 9 on larger variants, 6 on the smallest
)
(
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  rstn_i,
    // register port
    input  wire logic [AMS_ADDR_W-1:0] addr_i,
    input  wire logic [AMS_DATA_W-1:0] wr_data_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic      [AMS_DATA_W-1:0] rd_data_o,
    // converter core
    input  wire logic                  sample_done_i,
    output ams_mux_sel_t               mux_sel_o,
    output logic      [8:0]            pin_digital_o,
    output logic                       resolution_mode_o
);

    localparam bit LARGE_VARIANT = (AN_COUNT > AMS_SMALL_AN);

    // software-visible registers
    logic [15:0]  ch123_input_select_reg;
    logic [15:0]  ch0_input_select_reg;
    logic [15:0]  scan_input_mask_low_reg;
    logic [15:0]  pin_analog_config_low_reg;
    logic [15:0]  ctrl_reg;
    logic [15:0]  rd_data_reg;

    // sequencing state
    ams_set_t     set_reg;
    ams_set_t     set_next;
    logic [3:0]   scan_ptr_reg;
    logic [3:0]   scan_ptr_next;

    // outputs held in flops
    ams_mux_sel_t mux_sel_reg;
    ams_mux_sel_t mux_sel_next;
    logic [8:0]   pin_dig_reg;
    logic [8:0]   pin_dig_next;

    // decoded control bits
    logic         resolution_mode_bit;
    logic         scan_enable_bit;
    logic         alternate_sample_bit;
    logic         converter_module_disable;
    logic [15:0]  status_word;
    logic [15:0]  rd_mux;

    assign resolution_mode_bit      = ctrl_reg[AMS_CTRL_RES_MODE];  // [R1]
    assign scan_enable_bit          = ctrl_reg[AMS_CTRL_SCAN_EN];
    assign alternate_sample_bit     = ctrl_reg[AMS_CTRL_ALT];
    assign converter_module_disable = ctrl_reg[AMS_CTRL_DISABLE];

    // register writes, masked so unimplemented bits never store
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            ch123_input_select_reg    <= AMS_REG_RESET;  // [R16]
            ch0_input_select_reg      <= AMS_REG_RESET;  // [R16]
            scan_input_mask_low_reg   <= AMS_REG_RESET;  // [R16]
            pin_analog_config_low_reg <= AMS_REG_RESET;  // [R16]
            ctrl_reg                  <= AMS_REG_RESET;
        end
        else if (wr_i)
        begin
            unique case (addr_i)
                AMS_ADDR_CH123: ch123_input_select_reg <= wr_data_i & AMS_CH123_MASK;  // [R10]
                AMS_ADDR_CH0:   ch0_input_select_reg   <= wr_data_i & AMS_CH0_MASK;    // [R10]
                // every mask bit stays writable whatever the variant
                AMS_ADDR_SCAN:  scan_input_mask_low_reg   <= wr_data_i & AMS_SCAN_MASK;  // [R10] [R12]
                AMS_ADDR_PIN_DIGITAL_MODE_BITS:  pin_analog_config_low_reg <= wr_data_i & AMS_PIN_DIGITAL_MODE_BITS_MASK;  // [R10] [R14]
                AMS_ADDR_CTRL:  ctrl_reg <= wr_data_i & AMS_CTRL_MASK;
                default:        ;  // status and unmapped indices ignore writes
            endcase
        end
    end

    // status word shows the live sample set and scan position
    always_comb
    begin
        status_word                 = 16'h0000;
        status_word[3:0]            = scan_ptr_reg;
        status_word[AMS_STAT_SET_B] = (set_reg == AMS_SET_B);
    end

    // read multiplexer; unmapped indices answer zero
    always_comb
    begin
        unique case (addr_i)
            AMS_ADDR_CH123:  rd_mux = ch123_input_select_reg;
            AMS_ADDR_CH0:    rd_mux = ch0_input_select_reg;
            AMS_ADDR_SCAN:   rd_mux = scan_input_mask_low_reg;
            AMS_ADDR_PIN_DIGITAL_MODE_BITS:   rd_mux = pin_analog_config_low_reg;
            AMS_ADDR_CTRL:   rd_mux = ctrl_reg;
            AMS_ADDR_STATUS: rd_mux = status_word;
            default:         rd_mux = 16'h0000;
        endcase
    end

    // read data stand in the cycle after the strobe only
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
            rd_data_reg <= 16'h0000;
        else if (rd_i)
            rd_data_reg <= rd_mux;  // [R10]
        else
            rd_data_reg <= 16'h0000;
    end

    // sample set sequencing: toggles per sample only while alternating
    always_comb
    begin
        set_next = set_reg;
        if (!alternate_sample_bit)
            set_next = AMS_SET_A;  // [R18]
        else if (sample_done_i)
            set_next = (set_reg == AMS_SET_A) ? AMS_SET_B : AMS_SET_A;  // [R18]
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
            set_reg <= AMS_SET_A;
        else
            set_reg <= set_next;
    end

    // next enabled scan position above the current one
    ams_scan_next ams_scan_next_inst
    (
        .mask_i (scan_input_mask_low_reg[8:0]),
        .cur_i  (scan_ptr_reg),
        .next_o (scan_ptr_next)
    );

    // scan advances only after a set A sample, since set B never scans
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
            scan_ptr_reg <= 4'h0;
        else if (scan_enable_bit && sample_done_i && (set_reg == AMS_SET_A))
            scan_ptr_reg <= scan_ptr_next;  // [R11] [R19]
    end

    // decode the selects of whichever set is in force
    always_comb
    begin
        logic [4:0] pos_code;
        logic [1:0] neg_code;
        logic       pos_bit;
        logic       scanning;
        logic       present;
        pos_code     = 5'h00;
        neg_code     = 2'h0;
        pos_bit      = 1'b0;
        scanning     = 1'b0;
        present      = 1'b0;
        mux_sel_next = '0;
        mux_sel_next.set_b = (set_reg == AMS_SET_B);

        if (set_reg == AMS_SET_A)
        begin
            scanning = scan_enable_bit;
            pos_code = scanning ? {1'b0, scan_ptr_reg}                           // [R17]
                                : ch0_input_select_reg[AMS_FIRST_POS_A_LSB +: 5];  // [R9]
            mux_sel_next.ch0_neg_an1 = ch0_input_select_reg[AMS_FIRST_NEG_A];  // [R8]
            neg_code = ch123_input_select_reg[AMS_GRP_NEG_A_LSB +: 2];  // [R4]
            pos_bit  = ch123_input_select_reg[AMS_GRP_POS_A];  // [R5]
        end
        else
        begin
            pos_code = ch0_input_select_reg[AMS_FIRST_POS_B_LSB +: 5];  // [R7]
            mux_sel_next.ch0_neg_an1 = ch0_input_select_reg[AMS_FIRST_NEG_B];  // [R6]
            neg_code = ch123_input_select_reg[AMS_GRP_NEG_B_LSB +: 2];  // [R2]
            pos_bit  = ch123_input_select_reg[AMS_GRP_POS_B];  // [R3]
        end

        // channel 0 positive: code N is input N when the variant has it
        present = (pos_code < 5'(AN_COUNT));  // [R7] [R9]
        mux_sel_next.ch0_pos      = present ? pos_code[3:0] : 4'h0;
        mux_sel_next.ch0_low_ref  = scanning && !present;  // [R12]
        mux_sel_next.ch0_reserved = !scanning && !present;

        // channels 1..3 only exist in 10-bit mode
        mux_sel_next.grp_pos_upper = !resolution_mode_bit && pos_bit;  // [R1] [R3] [R5]
        mux_sel_next.grp_neg_an678 = !resolution_mode_bit && LARGE_VARIANT
                                     && (neg_code == AMS_NEG_AN678);  // [R2] [R4]
        mux_sel_next.grp_reserved  = resolution_mode_bit                   // [R1]
                                     || (neg_code == AMS_NEG_RSVD)
                                     || ((neg_code == AMS_NEG_AN678) && !LARGE_VARIANT);  // [R2] [R4]
    end

    // pin mode per input; absent pins never switch anything
    genvar gp;
    generate
        for (gp = 0; gp < AMS_NUM_AN; gp = gp + 1)
        begin : g_pin
            if (gp < AN_COUNT)
            begin : g_present
                // disable forces digital so a powered-down converter never loads a pin
                assign pin_dig_next[gp] = converter_module_disable  // [R15]
                                          || pin_analog_config_low_reg[gp];  // [R13]
            end
            else
            begin : g_absent
                assign pin_dig_next[gp] = 1'b0;  // [R14]
            end
        end
    endgenerate

    // output flops: selects follow the live set one cycle later
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            mux_sel_reg <= '0;
            pin_dig_reg <= 9'h000;
        end
        else
        begin
            mux_sel_reg <= mux_sel_next;
            pin_dig_reg <= pin_dig_next;
        end
    end

    // mode flop copy so the output comes straight from a flop
    logic res_mode_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
            res_mode_reg <= 1'b0;
        else
            res_mode_reg <= resolution_mode_bit;  // [R1]
    end

    assign rd_data_o         = rd_data_reg;
    assign mux_sel_o         = mux_sel_reg;
    assign pin_digital_o     = pin_dig_reg;
    assign resolution_mode_o = res_mode_reg;

endmodule // ams_input_select

// file: dv/ams_core_model.sv
// converter core stand-in: ends one sample a programmable gap after a start.
// assumes the bench pulses start_i for one cycle and waits for the done pulse.
`timescale 1ns/1ps

module ams_core_model
(
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    // bench control
    input  wire logic       start_i,
    input  wire logic [3:0] gap_i,
    // to the selection block
    output logic            sample_done_o
);
    logic [3:0] cnt_reg;
    logic       busy_reg;

    // gap lets one sample end at once and the next one late
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            cnt_reg       <= 4'h0;
            busy_reg      <= 1'b0;
            sample_done_o <= 1'b0;
        end
        else
        begin
            sample_done_o <= 1'b0;
            if (start_i && !busy_reg)
            begin
                busy_reg <= 1'b1;
                cnt_reg  <= gap_i;
            end
            else if (busy_reg && cnt_reg == 4'h0)
            begin
                busy_reg      <= 1'b0;
                sample_done_o <= 1'b1;
            end
            else if (busy_reg)
                cnt_reg <= cnt_reg - 4'h1;
        end
    end
endmodule // ams_core_model

// file: dv/ams_input_select_monitor.sv
// port checker for the input-selection block.
// assumes it is bound to every instance with a matching AN_COUNT.
`timescale 1ns/1ps

module ams_input_select_monitor
    import ams_pkg::*;
#(
    parameter int unsigned AN_COUNT = AMS_NUM_AN
)
(
    input wire logic                  core_clk_i,
    input wire logic                  rstn_i,
    input wire logic [AMS_ADDR_W-1:0] addr_i,
    input wire logic [AMS_DATA_W-1:0] wr_data_i,
    input wire logic                  wr_i,
    input wire logic                  rd_i,
    input wire logic [AMS_DATA_W-1:0] rd_data_o,
    input wire logic                  sample_done_i,
    input wire ams_mux_sel_t          mux_sel_o,
    input wire logic [8:0]            pin_digital_o,
    input wire logic                  resolution_mode_o
);
    // pins that exist on this variant
    localparam logic [8:0] PRESENT = 9'((1 << AN_COUNT) - 1);

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    a_read_window: assert property (rd_data_o != 16'h0000 |-> $past(rd_i))
        else $error("read data outside read cycle");
    a_unmapped_zero: assert property (rd_i && addr_i > 3'h5 |=> rd_data_o == 16'h0000)
        else $error("unmapped read not zero");
    a_mode_follow: assert property ((wr_i && addr_i == AMS_ADDR_CTRL) ##1 !(wr_i && addr_i == AMS_ADDR_CTRL)
        |=> resolution_mode_o == $past(wr_data_i[AMS_CTRL_RES_MODE], 2)) else $error("mode not taken");
    // both sides stable for a cycle so output timing skew cannot matter
    a_grp_wide_mode: assert property (resolution_mode_o && $past(resolution_mode_o)
        |-> mux_sel_o.grp_reserved && !mux_sel_o.grp_pos_upper && !mux_sel_o.grp_neg_an678)
        else $error("group select live in wide mode");
    a_neg_upper: assert property (mux_sel_o.grp_neg_an678 |-> !mux_sel_o.grp_reserved)
        else $error("upper negative with reserved code");
    a_ch0_range: assert property (!mux_sel_o.ch0_reserved && !mux_sel_o.ch0_low_ref
        |-> mux_sel_o.ch0_pos < AN_COUNT) else $error("channel 0 input out of range");
    a_ch0_noinput: assert property (mux_sel_o.ch0_reserved || mux_sel_o.ch0_low_ref
        |-> mux_sel_o.ch0_pos == 4'h0) else $error("channel 0 index with no input");
    a_absent_pins: assert property ((pin_digital_o & ~PRESENT) == 9'h000)
        else $error("absent pin driven");
    a_off_digital: assert property ((wr_i && addr_i == AMS_ADDR_CTRL && wr_data_i[AMS_CTRL_DISABLE])
        ##1 !(wr_i && addr_i == AMS_ADDR_CTRL) |=> pin_digital_o == PRESENT) else $error("pins not digital");
    a_set_b_cause: assert property ($rose(mux_sel_o.set_b) |-> $past(sample_done_i, 2))
        else $error("set changed without sample");
endmodule // ams_input_select_monitor

bind ams_input_select ams_input_select_monitor #(.AN_COUNT(AN_COUNT)) ams_input_select_monitor_inst
    (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
     .rd_i(rd_i), .rd_data_o(rd_data_o), .sample_done_i(sample_done_i), .mux_sel_o(mux_sel_o),
     .pin_digital_o(pin_digital_o), .resolution_mode_o(resolution_mode_o));

// file: dv/tb_ams_input_select.sv
// self-checking bench for the input-selection block with a core stand-in.
// assumes the package constants and a 100 MHz core clock.
`timescale 1ns/1ps

module tb_ams_input_select;
    import ams_pkg::*;

    logic         core_clk_i = 1'b0;
    logic         rstn_i     = 1'b0;
    logic [2:0]   addr_i     = 3'h0;
    logic [15:0]  wr_data_i  = 16'h0000;
    logic         wr_i       = 1'b0;
    logic         rd_i       = 1'b0;
    logic         start      = 1'b0;
    logic [3:0]   gap        = 4'h0;
    logic         sample_done;
    logic [15:0]  rd_data_o;
    ams_mux_sel_t mux_sel_o;
    logic [8:0]   pin_digital_o;
    logic         resolution_mode_o;
    logic [15:0]  rd_data_s;
    ams_mux_sel_t mux_sel_s;
    logic [8:0]   pin_digital_s;
    logic         resolution_mode_s;
    int           fail_count      = 0;
    int           samples_checked = 0;

    always #5 core_clk_i = ~core_clk_i;

    ams_input_select ams_input_select_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .sample_done_i(sample_done),
        .mux_sel_o(mux_sel_o), .pin_digital_o(pin_digital_o), .resolution_mode_o(resolution_mode_o));
    ams_core_model ams_core_model_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .start_i(start),
        .gap_i(gap), .sample_done_o(sample_done));
    // smallest variant on the same bus, so absent inputs and pins get exercised
    ams_input_select #(.AN_COUNT(AMS_SMALL_AN)) ams_input_select_small_inst (.core_clk_i(core_clk_i),
        .rstn_i(rstn_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_s),
        .sample_done_i(sample_done), .mux_sel_o(mux_sel_s), .pin_digital_o(pin_digital_s),
        .resolution_mode_o(resolution_mode_s));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_sel(input ams_mux_sel_t exp);
        samples_checked++;
        if (mux_sel_o !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: select %h expected %h", $time, mux_sel_o, exp);
        end
    endtask

    function automatic ams_mux_sel_t sel(input logic b, input logic [3:0] p, input logic [5:0] f);
        return {b, p, f};
    endfunction

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        addr_i    <= a;
        wr_data_i <= d;
        wr_i      <= 1'b1;
        @(posedge core_clk_i);
        wr_i      <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge core_clk_i);
        rd_i   <= 1'b0;
        #1 chk16(rd_data_o, exp);
    endtask

    // outputs trail the registers by a cycle, so let two edges pass
    task automatic settle();
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask

    task automatic sample(input logic [3:0] g);
        int n;
        n = 0;
        @(posedge core_clk_i);
        gap   <= g;
        start <= 1'b1;
        @(posedge core_clk_i);
        start <= 1'b0;
        do
        begin
            @(posedge core_clk_i);
            #1 n++;
        end while (!sample_done && n < 40);
        if (n >= 40)
            chk16(16'h0001, 16'h0000);
        settle();
    endtask

    task automatic t_reset();
        for (int i = 0; i < 5; i++)
            rd(3'(i), 16'h0000);
        chk16({7'h00, pin_digital_o}, 16'h0000);
        chk16({7'h00, pin_digital_s}, 16'h0000);
        chk_sel(sel(1'b0, 4'h0, 6'h00));
        chk16({15'h0000, resolution_mode_o}, 16'h0000);
    endtask

    // all-ones write shows which bits exist; status and holes stay zero
    task automatic t_masks();
        logic [15:0] m [5];
        m = '{AMS_CH123_MASK, AMS_CH0_MASK, AMS_SCAN_MASK, AMS_PIN_DIGITAL_MODE_BITS_MASK, AMS_CTRL_MASK};
        for (int i = 0; i < 5; i++)
        begin
            wr(3'(i), 16'hffff);
            rd(3'(i), m[i]);
            wr(3'(i), 16'h0000);
        end
        wr(AMS_ADDR_STATUS, 16'hffff);
        rd(AMS_ADDR_STATUS, 16'h0000);
        wr(3'h7, 16'hffff);
        rd(3'h7, 16'h0000);
    endtask

    task automatic t_ch0();
        logic [4:0] c;
        for (int i = 0; i < 10; i++)
        begin
            c = 5'(i);
            wr(AMS_ADDR_CH0, {8'h00, c[0], 2'b00, c});
            settle();
            if (i < 9)
                chk_sel(sel(1'b0, c[3:0], {1'b0, c[0], 4'h0}));
            else
                chk_sel(sel(1'b0, 4'h0, {1'b0, c[0], 4'h2}));
        end
        wr(AMS_ADDR_CH0, 16'h0000);
    endtask

    task automatic t_grp();
        logic [1:0] n;
        for (int i = 0; i < 4; i++)
        begin
            n = 2'(i);
            wr(AMS_ADDR_CH123, {13'h0000, n, n[0]});
            settle();
            if (i < 3)
                chk_sel(sel(1'b0, 4'h0, {2'b00, n[0], n == 2'h2, 2'b00}));
            else
                chk16({15'h0000, mux_sel_o.grp_reserved}, 16'h0001);
        end
        wr(AMS_ADDR_CTRL, 16'h0001);
        wr(AMS_ADDR_CH123, 16'h0005);
        settle();
        chk_sel(sel(1'b0, 4'h0, 6'h01));
        chk16({15'h0000, resolution_mode_o}, 16'h0001);
        wr(AMS_ADDR_CTRL, 16'h0000);
    endtask

    // set A and B differ in every field so a wrong set shows at once
    task automatic t_alt();
        wr(AMS_ADDR_CH0, 16'h8803);
        wr(AMS_ADDR_CH123, 16'h0502);
        wr(AMS_ADDR_CTRL, 16'h0004);
        settle();
        chk_sel(sel(1'b0, 4'h3, 6'h00));
        sample(4'h0);
        chk_sel(sel(1'b1, 4'h8, 6'h1c));
        rd(AMS_ADDR_STATUS, 16'h0010);
        sample(4'h5);
        chk_sel(sel(1'b0, 4'h3, 6'h00));
        wr(AMS_ADDR_CTRL, 16'h0000);
        wr(AMS_ADDR_CH123, 16'h0000);
    endtask

    task automatic t_scan();
        logic [3:0] exp [3];
        exp = '{4'h2, 4'h8, 4'h2};
        wr(AMS_ADDR_CH0, 16'h0000);
        wr(AMS_ADDR_SCAN, 16'h0104);
        wr(AMS_ADDR_CTRL, 16'h0002);
        settle();
        chk_sel(sel(1'b0, 4'h0, 6'h00));
        for (int i = 0; i < 3; i++)
        begin
            sample(4'(i));
            chk_sel(sel(1'b0, exp[i], 6'h00));
        end
        wr(AMS_ADDR_CTRL, 16'h0000);
    endtask

    // smallest variant: absent inputs read back but never route
    task automatic t_small();
        wr(AMS_ADDR_SCAN, 16'h01ff);
        rd(AMS_ADDR_SCAN, 16'h01ff);
        chk16(rd_data_s, 16'h01ff);
        wr(AMS_ADDR_SCAN, 16'h0080);
        wr(AMS_ADDR_CH123, 16'h0004);
        wr(AMS_ADDR_CTRL, 16'h0002);
        sample(4'h0);
        chk_sel(sel(1'b0, 4'h7, 6'h04));
        chk16({5'h00, mux_sel_s}, {5'h00, sel(1'b0, 4'h0, 6'h21)});
        wr(AMS_ADDR_CTRL, 16'h0000);
        wr(AMS_ADDR_CH0, 16'h0006);
        wr(AMS_ADDR_PIN_DIGITAL_MODE_BITS, 16'h01ff);
        settle();
        chk_sel(sel(1'b0, 4'h6, 6'h04));
        chk16({5'h00, mux_sel_s}, {5'h00, sel(1'b0, 4'h0, 6'h03)});
        chk16({7'h00, pin_digital_s}, 16'h003f);
        wr(AMS_ADDR_CH0, 16'h0000);
        wr(AMS_ADDR_CH123, 16'h0000);
        wr(AMS_ADDR_PIN_DIGITAL_MODE_BITS, 16'h0000);
    endtask

    task automatic t_pins();
        wr(AMS_ADDR_PIN_DIGITAL_MODE_BITS, 16'h0155);
        settle();
        chk16({7'h00, pin_digital_o}, 16'h0155);
        wr(AMS_ADDR_CTRL, 16'h0008);
        settle();
        chk16({7'h00, pin_digital_o}, 16'h01ff);
        wr(AMS_ADDR_CTRL, 16'h0000);
        settle();
        chk16({7'h00, pin_digital_o}, 16'h0155);
    endtask

    initial
    begin
        repeat (16) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        t_reset();
        t_masks();
        t_ch0();
        t_grp();
        t_alt();
        t_scan();
        t_small();
        t_pins();
        // load registers, then a reset in mid-run must clear them again
        wr(AMS_ADDR_CH0, 16'h9f9f);
        wr(AMS_ADDR_CTRL, 16'h0003);
        @(posedge core_clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        t_reset();
        tally_and_finish();
    end

    // whole run is a few hundred cycles; this cuts a hang short
    initial
    begin
        #100us;
        fail_count++;
        tally_and_finish();
    end
endmodule // tb_ams_input_select
